// ---- dsp_sequencer.sv ----
// Purpose: Platform sequencer end that ramps both sockets' SOC domains
// Assumes: Regulator power-good pins are asynchronous and are synchronised
// Notes: Socket 1 starts only after socket 0 is fully up

`timescale 1ns/1ns

module dsp_sequencer
  import dsp_pkg::*;
#(
  parameter int PG_TIMEOUT = PG_TIMEOUT_CYCLES,
  parameter int STEP_DELAY = STEP_DELAY_CYCLES
)
(
  // Clock and reset
  input logic REF_CLK,
  input logic RESET,
  // Link to both sockets
  dsp_link_if.sequencer LINK,
  // Platform power request, level
  input logic START,
  // SOC-domain regulator enables, one bit per socket, REST_RAILS bits per socket for REST_EN
  output logic [NUM_SOCKETS-1:0] SOC_CORE_EN,
  output logic [NUM_SOCKETS-1:0] SERDES_CORE_EN,
  output logic [NUM_SOCKETS-1:0] SOC_1V8_EN,
  output logic [NUM_SOCKETS*REST_RAILS-1:0] REST_EN,
  // SOC-domain regulator power-goods
  input logic [NUM_SOCKETS-1:0] SOC_CORE_PG,
  input logic [NUM_SOCKETS-1:0] SERDES_CORE_PG,
  input logic [NUM_SOCKETS-1:0] SOC_1V8_PG,
  input logic [NUM_SOCKETS*REST_RAILS-1:0] REST_PG,
  // Core-complex rail chain
  input logic [NUM_SOCKETS-1:0] CORE_0V75_PG,
  output logic [NUM_SOCKETS-1:0] CORE_1V8_EN,
  input logic [NUM_SOCKETS-1:0] CORE_1V8_PG,
  // Status
  output logic ALL_UP,
  output logic FAULT
);

  // ----------------------------------------------------------------------
  // Power-good synchronisers
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 5 * NUM_SOCKETS + NUM_SOCKETS * REST_RAILS;
  localparam int TIMER_W = $clog2(PG_TIMEOUT + 1);

  typedef enum {ST_IDLE, ST_RAMP, ST_SOC_GOOD, ST_RELEASE, ST_RUN, ST_SHUTDOWN} dsp_seq_state_t;

  logic [SYNC_W-1:0] pg_meta;
  logic [SYNC_W-1:0] pg_sync;
  logic [NUM_SOCKETS-1:0] soc_core_pg;
  logic [NUM_SOCKETS-1:0] serdes_core_pg;
  logic [NUM_SOCKETS-1:0] soc_1v8_pg;
  logic [NUM_SOCKETS-1:0] core_0v75_pg;
  logic [NUM_SOCKETS-1:0] core_1v8_pg;
  logic [NUM_SOCKETS*REST_RAILS-1:0] rest_pg;

  // Two flops on every regulator pin
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      pg_meta <= '0;
      pg_sync <= '0;
    end
    else
    begin
      pg_meta <= {REST_PG, CORE_1V8_PG, CORE_0V75_PG, SOC_1V8_PG, SERDES_CORE_PG, SOC_CORE_PG};
      pg_sync <= pg_meta;
    end
  end

  assign {rest_pg, core_1v8_pg, core_0v75_pg, soc_1v8_pg, serdes_core_pg, soc_core_pg} = pg_sync;

  // ----------------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------------
  dsp_seq_state_t state;
  dsp_seq_state_t next_state;
  logic sock;
  logic next_sock;
  logic [1:0] stage [NUM_SOCKETS];
  logic [1:0] next_stage [NUM_SOCKETS];
  logic [NUM_SOCKETS-1:0] soc_good;
  logic [NUM_SOCKETS-1:0] next_soc_good;
  logic rst_n;
  logic next_rst_n;
  logic pwr_ctrl;
  logic next_pwr_ctrl;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic fault;
  logic next_fault;
  logic [NUM_SOCKETS-1:0] core_1v8_en;
  logic [NUM_SOCKETS-1:0] next_core_1v8_en;
  logic [NUM_SOCKETS-1:0] core_pg;
  logic [NUM_SOCKETS-1:0] next_core_pg;
  logic [NUM_SOCKETS-1:0] sock_good;
  logic cur_good;

  // Power-good of the stage the current socket is waiting on
  always_comb
  begin
    cur_good = 1'b0;
    unique case (stage[sock])
      STAGE_OFF: cur_good = 1'b0;
      STAGE_CORE: cur_good = soc_core_pg[sock] && serdes_core_pg[sock];
      STAGE_1V8: cur_good = soc_1v8_pg[sock];
      STAGE_REST: cur_good = &rest_pg[sock*REST_RAILS +: REST_RAILS];
    endcase
  end

  // Whole SOC domain of each socket still good
  genvar s;
  generate
    for (s = 0; s < NUM_SOCKETS; s++)
    begin : g_sock
      assign sock_good[s] = soc_core_pg[s] && serdes_core_pg[s] && soc_1v8_pg[s] &&
                            (&rest_pg[s*REST_RAILS +: REST_RAILS]);
      // Enables follow the stage reached, earlier stages stay on
      assign SOC_CORE_EN[s] = (stage[s] != STAGE_OFF);
      assign SERDES_CORE_EN[s] = (stage[s] != STAGE_OFF);
      assign SOC_1V8_EN[s] = (stage[s] >= STAGE_1V8);
      // All remaining rails switch in the same cycle
      assign REST_EN[s*REST_RAILS +: REST_RAILS] = {REST_RAILS{stage[s] == STAGE_REST}};
    end
  endgenerate

  // Next sequencing state
  always_comb
  begin
    next_state = state;
    next_sock = sock;
    next_stage = stage;
    next_soc_good = soc_good;
    next_rst_n = rst_n;
    next_pwr_ctrl = pwr_ctrl;
    next_timer = timer;
    next_fault = fault;
    unique case (state)
      ST_IDLE:
      begin
        next_timer = '0;
        if (!START)
          next_fault = 1'b0;
        else if (!fault)
        begin
          next_state = ST_RAMP;
          next_sock = 1'b0;
        end
      end
      ST_RAMP:
      begin
        if (!START)
        begin
          next_state = ST_SHUTDOWN;
          next_timer = '0;
        end
        else if (stage[sock] == STAGE_OFF)
        begin
          next_stage[sock] = STAGE_CORE;
          next_timer = '0;
        end
        else if (cur_good)
        begin
          next_timer = '0;
          if (stage[sock] == STAGE_REST)
            next_state = ST_SOC_GOOD;
          else
            next_stage[sock] = stage[sock] + 2'h1;
        end
        else if (timer == TIMER_W'(PG_TIMEOUT))
        begin
          next_fault = 1'b1; // Rail never came good
          next_state = ST_SHUTDOWN;
          next_timer = '0;
        end
        else
          next_timer = timer + 1'b1;
      end
      ST_SOC_GOOD:
      begin
        next_soc_good[sock] = 1'b1;
        if (sock == 1'b0)
        begin
          next_sock = 1'b1;
          next_state = ST_RAMP;
        end
        else
          next_state = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        next_rst_n = 1'b1;
        next_pwr_ctrl = 1'b1;
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!START || (sock_good != {NUM_SOCKETS{1'b1}}))
        begin
          if (sock_good != {NUM_SOCKETS{1'b1}})
            next_fault = 1'b1;
          next_rst_n = 1'b0;
          next_pwr_ctrl = 1'b0;
          next_soc_good = '0;
          next_timer = '0;
          next_state = ST_SHUTDOWN;
        end
      end
      ST_SHUTDOWN:
      begin
        next_rst_n = 1'b0;
        next_pwr_ctrl = 1'b0;
        next_soc_good = '0;
        if (timer != TIMER_W'(STEP_DELAY))
          next_timer = timer + 1'b1;
        else
        begin
          // Unwind socket 1 first, then socket 0, last stage first
          next_timer = '0;
          if (stage[1] != STAGE_OFF)
            next_stage[1] = stage[1] - 2'h1;
          else if (stage[0] != STAGE_OFF)
            next_stage[0] = stage[0] - 2'h1;
          else
            next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Core-complex chain and core power-good pin
  always_comb
  begin
    next_core_1v8_en = core_0v75_pg & {NUM_SOCKETS{rst_n}};
    next_core_pg = core_1v8_pg & core_1v8_en;
  end

  // Sequencing registers
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state <= ST_IDLE;
      sock <= 1'b0;
      stage <= '{default: STAGE_OFF};
      soc_good <= '0;
      rst_n <= 1'b0;
      pwr_ctrl <= 1'b0;
      timer <= '0;
      fault <= 1'b0;
      core_1v8_en <= '0;
      core_pg <= '0;
    end
    else
    begin
      state <= next_state;
      sock <= next_sock;
      stage <= next_stage;
      soc_good <= next_soc_good;
      rst_n <= next_rst_n;
      pwr_ctrl <= next_pwr_ctrl;
      timer <= next_timer;
      fault <= next_fault;
      core_1v8_en <= next_core_1v8_en;
      core_pg <= next_core_pg;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign LINK.soc_domain_power_good_in = soc_good;
  assign LINK.socket_reset_n = {NUM_SOCKETS{rst_n}};
  assign LINK.core_domain_power_ctrl = {NUM_SOCKETS{pwr_ctrl}};
  assign LINK.core_domain_power_good_in = core_pg;
  assign CORE_1V8_EN = core_1v8_en;
  assign ALL_UP = (state == ST_RUN);
  assign FAULT = fault;

endmodule : dsp_sequencer

// ---- dsp_pkg.sv ----
// Purpose: Shared constants for the dual socket power sequencing link
// Assumes: Both ends run on REF_CLK at 100 MHz
// Notes: Timing figures are kept in their own unit and turned into cycles here

package dsp_pkg;

  // ----------------------------------------------------------------------
  // Topology
  // ----------------------------------------------------------------------
  localparam int NUM_SOCKETS = 2;
  // Remaining SOC rails: SerDes high voltage, 3.3 V, memory io, DIMM 2.5 V
  localparam int REST_RAILS = 4;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int PG_TIMEOUT_US = 50_000;
  localparam int PG_TIMEOUT_CYCLES = PG_TIMEOUT_US * (1000 / CLK_PERIOD_NS);
  localparam int STEP_DELAY_US = 100;
  localparam int STEP_DELAY_CYCLES = STEP_DELAY_US * (1000 / CLK_PERIOD_NS);
  localparam int ALERT_SETTLE_NS = 200;
  localparam int ALERT_SETTLE_CYCLES = (ALERT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Regulator bus rates, one quarter of a bit period each
  // ----------------------------------------------------------------------
  localparam int PMBUS_STD_HZ = 100_000;
  localparam int PMBUS_FAST_HZ = 1_000_000;
  localparam int QTR_STD = CLK_HZ / (4 * PMBUS_STD_HZ);
  localparam int QTR_FAST = CLK_HZ / (4 * PMBUS_FAST_HZ);

  // ----------------------------------------------------------------------
  // Write frame layout: start, address, command, data, three acks, stop
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS = 27;
  localparam logic [4:0] SLOT_START = 5'h00;
  localparam logic [4:0] SLOT_ACK_ADDR = 5'h09;
  localparam logic [4:0] SLOT_ACK_CMD = 5'h12;
  localparam logic [4:0] SLOT_ACK_DATA = 5'h1b;
  localparam logic [4:0] SLOT_STOP = 5'h1c;

  // ----------------------------------------------------------------------
  // Regulator stage of one socket
  // ----------------------------------------------------------------------
  localparam logic [1:0] STAGE_OFF = 2'h0;
  localparam logic [1:0] STAGE_CORE = 2'h1;
  localparam logic [1:0] STAGE_1V8 = 2'h2;
  localparam logic [1:0] STAGE_REST = 2'h3;

endpackage : dsp_pkg

// ---- dsp_link_if.sv ----
// Purpose: Pins between the platform sequencer and the two sockets
// Assumes: Alert line is open drain with a pull-up
// Notes: Wire level of the alert line is resolved here from the enables

`timescale 1ns/1ns

interface dsp_link_if;
  import dsp_pkg::*;

  // ----------------------------------------------------------------------
  // Sequencer to sockets
  // ----------------------------------------------------------------------
  logic [NUM_SOCKETS-1:0] soc_domain_power_good_in;
  logic [NUM_SOCKETS-1:0] socket_reset_n;
  logic [NUM_SOCKETS-1:0] core_domain_power_ctrl;
  logic [NUM_SOCKETS-1:0] core_domain_power_good_in;

  // ----------------------------------------------------------------------
  // Shared boot handoff line
  // ----------------------------------------------------------------------
  logic [NUM_SOCKETS-1:0] alert_o;
  logic [NUM_SOCKETS-1:0] alert_oe;
  logic boot_handoff_alert_n;

  // Any enabled driver pulls low, otherwise the pull-up wins
  assign boot_handoff_alert_n = ~|(alert_oe & ~alert_o);

  modport sequencer (
    output soc_domain_power_good_in,
    output socket_reset_n,
    output core_domain_power_ctrl,
    output core_domain_power_good_in
  );

  modport socket (
    input soc_domain_power_good_in,
    input socket_reset_n,
    input core_domain_power_ctrl,
    input core_domain_power_good_in,
    input boot_handoff_alert_n,
    output alert_o,
    output alert_oe
  );

endinterface : dsp_link_if

// ---- dsp_socket.sv ----
// Purpose: One processor socket end: boot handoff, core rail bring-up, PMBus writes
// Assumes: Link pins arrive from another clock domain and are synchronised
// Notes: Instantiate once per socket with SOCKET set to 0 or 1

`timescale 1ns/1ns

module dsp_socket
  import dsp_pkg::*;
#(
  parameter int SOCKET = 0,
  parameter logic [6:0] CORE_RAIL_ADDR = 7'h20,
  parameter int ALERT_SETTLE = ALERT_SETTLE_CYCLES
)
(
  // Clock and reset
  input logic REF_CLK,
  input logic RESET,
  // Link to the sequencer and the other socket
  dsp_link_if.socket LINK,
  // Boot status
  output logic BOOT_ACTIVE,
  output logic SEQ_DONE,
  // Core-complex 0.75 V regulator enable
  output logic CORE_0V75_EN,
  // Power management modes
  input logic MAX_FREQ_MODE,
  input logic AVS_ENABLE,
  input logic MONITOR_ENABLE,
  // PMBus write request
  input logic PM_REQ,
  input logic [6:0] PM_ADDR,
  input logic [7:0] PM_CMD,
  input logic [7:0] PM_DATA,
  output logic PM_BUSY,
  output logic PM_DONE,
  output logic PM_NACK,
  // Regulator I2C port pins
  output logic SCL_O,
  output logic SCL_OE,
  input logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  typedef enum {SK_RESET, SK_WAIT_HANDOFF, SK_BOOT, SK_DONE} dsp_sock_state_t;
  localparam int SETTLE_W = $clog2(ALERT_SETTLE + 1);

  logic [4:0] in_meta;
  logic [4:0] in_sync;
  logic rst_n_s;
  logic pwr_ctrl_s;
  logic core_pg_s;
  logic alert_s;
  logic sda_s;

  // Two flops on every pin input
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      in_meta <= 5'h00;
      in_sync <= 5'h00;
    end
    else
    begin
      in_meta <= {SDA_I, LINK.boot_handoff_alert_n, LINK.core_domain_power_good_in[SOCKET],
                  LINK.core_domain_power_ctrl[SOCKET], LINK.socket_reset_n[SOCKET]};
      in_sync <= in_meta;
    end
  end

  assign {sda_s, alert_s, core_pg_s, pwr_ctrl_s, rst_n_s} = in_sync;

  // ----------------------------------------------------------------------
  // Boot and core-domain sequencing
  // ----------------------------------------------------------------------
  dsp_sock_state_t state;
  dsp_sock_state_t next_state;
  logic [SETTLE_W-1:0] settle;
  logic [SETTLE_W-1:0] next_settle;

  // Next boot state
  always_comb
  begin
    next_state = state;
    next_settle = settle;
    if (!rst_n_s)
    begin
      next_state = SK_RESET;
      next_settle = '0;
    end
    else
    begin
      unique case (state)
        SK_RESET:
          if (pwr_ctrl_s)
            next_state = (SOCKET == 0) ? SK_BOOT : SK_WAIT_HANDOFF;
        SK_WAIT_HANDOFF:
          if (settle != SETTLE_W'(ALERT_SETTLE))
            next_settle = settle + 1'b1; // Let the first socket pull the line low
          else if (alert_s)
            next_state = SK_BOOT;
        SK_BOOT:
          if (core_pg_s)
            next_state = SK_DONE;
        SK_DONE:
          next_state = SK_DONE;
      endcase
    end
  end

  // Boot state registers
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state <= SK_RESET;
      settle <= '0;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
    end
  end

  // Management processor runs the core rail once enabled by the control pin
  assign CORE_0V75_EN = pwr_ctrl_s && (state == SK_BOOT || state == SK_DONE);
  assign BOOT_ACTIVE = (state == SK_BOOT);
  assign SEQ_DONE = (state == SK_DONE);
  // First socket holds the handoff line low while it boots
  assign LINK.alert_o[SOCKET] = 1'b0;
  assign LINK.alert_oe[SOCKET] = (SOCKET == 0) && (state == SK_BOOT);

  // ----------------------------------------------------------------------
  // PMBus write master on the regulator port
  // ----------------------------------------------------------------------
  logic busy;
  logic next_busy;
  logic [4:0] slot;
  logic [4:0] next_slot;
  logic [1:0] qtr;
  logic [1:0] next_qtr;
  logic [7:0] div;
  logic [7:0] next_div;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] next_frame;
  logic scl;
  logic next_scl;
  logic sda;
  logic next_sda;
  logic nack;
  logic next_nack;
  logic fast;
  logic next_fast;
  logic done;
  logic next_done;
  logic [7:0] qtr_last;
  logic pm_allowed;

  // Fast rate only for the core rail in maximum frequency mode, else 100 kHz
  assign qtr_last = fast ? 8'(QTR_FAST - 1) : 8'(QTR_STD - 1);
  assign pm_allowed = AVS_ENABLE || MONITOR_ENABLE;

  // Next frame position and acknowledge check
  always_comb
  begin
    next_busy = busy;
    next_slot = slot;
    next_qtr = qtr;
    next_div = div;
    next_frame = frame;
    next_nack = nack;
    next_fast = fast;
    next_done = 1'b0;
    if (!busy)
    begin
      if (PM_REQ && pm_allowed)
      begin
        // Address with write bit, command code, data byte, acks released
        next_busy = 1'b1;
        next_slot = SLOT_START;
        next_qtr = 2'h0;
        next_div = 8'h00;
        next_frame = {PM_ADDR, 1'b0, 1'b1, PM_CMD, 1'b1, PM_DATA, 1'b1};
        next_nack = 1'b0;
        next_fast = MAX_FREQ_MODE && (PM_ADDR == CORE_RAIL_ADDR);
      end
    end
    else if (div != qtr_last)
      next_div = div + 8'h01;
    else
    begin
      next_div = 8'h00;
      next_qtr = qtr + 2'h1;
      if (qtr == 2'h2 && sda_s &&
          (slot == SLOT_ACK_ADDR || slot == SLOT_ACK_CMD || slot == SLOT_ACK_DATA))
        next_nack = 1'b1;
      if (qtr == 2'h3)
      begin
        if (slot == SLOT_STOP)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
        else
        begin
          next_slot = slot + 5'h01;
          if (slot != SLOT_START)
            next_frame = {frame[FRAME_BITS-2:0], 1'b0};
        end
      end
    end
  end

  // Line levels for the coming quarter
  always_comb
  begin
    next_scl = 1'b1;
    next_sda = 1'b1;
    if (next_busy)
    begin
      if (next_slot == SLOT_START)
      begin
        next_scl = (next_qtr < 2'h2);
        next_sda = (next_qtr == 2'h0);
      end
      else if (next_slot == SLOT_STOP)
      begin
        next_scl = (next_qtr != 2'h0);
        next_sda = (next_qtr >= 2'h2);
      end
      else
      begin
        next_scl = (next_qtr == 2'h1) || (next_qtr == 2'h2);
        next_sda = next_frame[FRAME_BITS-1];
      end
    end
  end

  // PMBus master registers
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      busy <= 1'b0;
      slot <= 5'h00;
      qtr <= 2'h0;
      div <= 8'h00;
      frame <= '0;
      scl <= 1'b1;
      sda <= 1'b1;
      nack <= 1'b0;
      fast <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      busy <= next_busy;
      slot <= next_slot;
      qtr <= next_qtr;
      div <= next_div;
      frame <= next_frame;
      scl <= next_scl;
      sda <= next_sda;
      nack <= next_nack;
      fast <= next_fast;
      done <= next_done;
    end
  end

  // Open drain: drive low only
  assign SCL_O = 1'b0;
  assign SCL_OE = ~scl;
  assign SDA_O = 1'b0;
  assign SDA_OE = ~sda;
  assign PM_BUSY = busy;
  assign PM_DONE = done;
  assign PM_NACK = nack;

endmodule : dsp_socket

// ---- dsp_link_monitor.sv ----
// Purpose: Checks the sequencer to socket link over time
// Assumes: One REF_CLK domain, RESET synchronous and active high
// Notes: Sees interface signals only
`timescale 1ns/1ns
module dsp_link_monitor
  import dsp_pkg::*;
(
  // Clock and reset
  input logic REF_CLK,
  input logic RESET,
  // Link signals
  input logic [NUM_SOCKETS-1:0] soc_domain_power_good_in,
  input logic [NUM_SOCKETS-1:0] socket_reset_n,
  input logic [NUM_SOCKETS-1:0] core_domain_power_ctrl,
  input logic [NUM_SOCKETS-1:0] core_domain_power_good_in,
  input logic [NUM_SOCKETS-1:0] alert_o,
  input logic [NUM_SOCKETS-1:0] alert_oe,
  input logic boot_handoff_alert_n
);
  // ----------------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // Steps of the core bring-up
  sequence core0_up;
    $rose(core_domain_power_good_in[0]);
  endsequence
  sequence core1_up;
    $rose(core_domain_power_good_in[1]);
  endsequence

  rst_pair_a: assert property (socket_reset_n[0] == socket_reset_n[1])
    else $error("socket resets differ");
  rst_late_a: assert property ($rose(socket_reset_n[0])
    |-> $past(soc_domain_power_good_in) == 2'h3)
    else $error("reset released before both domains up");
  ctrl_rst_a: assert property (core_domain_power_ctrl == socket_reset_n)
    else $error("power control not with reset");
  pg_order_a: assert property ($rose(soc_domain_power_good_in[1])
    |-> soc_domain_power_good_in[0])
    else $error("socket 1 up before socket 0");
  s1_quiet_a: assert property (!alert_oe[1] && alert_o == 2'h0)
    else $error("alert driven wrongly");
  boot_first_a: assert property ($rose(alert_oe[0])
    |-> core_domain_power_good_in == 2'h0 && &socket_reset_n)
    else $error("alert pulled at wrong time");
  alert_free_a: assert property (core0_up |-> ##[1:4] boot_handoff_alert_n)
    else $error("alert not released");
  core_gate_a: assert property (core0_up |-> &socket_reset_n)
    else $error("core good while in reset");
  s1_after_a: assert property (core1_up
    |-> core_domain_power_good_in[0] && boot_handoff_alert_n)
    else $error("socket 1 core before handoff");
endmodule : dsp_link_monitor

// ---- dual_socket_power_sequencer_bench.sv ----
// Purpose: Self-checking bench for sequencer and both sockets
// Assumes: Regulators answer one cycle after their enable
// Notes: No regulator acks PMBus, so every frame ends in a nack
`timescale 1ns/1ns
module dual_socket_power_sequencer_bench
  import dsp_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals, models and instances
  // ----------------------------------------------------------------------
  typedef struct packed {logic mf; logic adaptive_voltage_scaling; logic mon; logic [6:0] ad; int q;} dsp_row_t;
  dsp_row_t rows [3] = '{'{1, 1, 0, 7'h20, QTR_FAST}, '{0, 0, 1, 7'h20, QTR_STD},
    '{1, 1, 1, 7'h21, QTR_STD}};
  logic REF_CLK, RESET, start, mf, adaptive_voltage_scaling, mon, rq;
  logic [6:0] ad;
  logic [1:0] kill, sce, see, s18, c18e, scp, sep, s18p, c75p, c18p;
  logic [1:0] ba, sd, c75e, busy, done, nack, sdaoe, scloe;
  logic [7:0] ren, rp;
  logic all_up, fault, scl_prev;
  int error_cnt, samples_checked, n, scl_falls;
  dsp_link_if link ();
  dsp_link_monitor u_mon (.REF_CLK(REF_CLK), .RESET(RESET),
    .soc_domain_power_good_in(link.soc_domain_power_good_in),
    .socket_reset_n(link.socket_reset_n), .core_domain_power_ctrl(link.core_domain_power_ctrl),
    .core_domain_power_good_in(link.core_domain_power_good_in), .alert_o(link.alert_o),
    .alert_oe(link.alert_oe), .boot_handoff_alert_n(link.boot_handoff_alert_n));
  dsp_sequencer #(.PG_TIMEOUT(200), .STEP_DELAY(8)) u_dsp_sequencer (.REF_CLK(REF_CLK),
    .RESET(RESET), .LINK(link), .START(start), .SOC_CORE_EN(sce), .SERDES_CORE_EN(see),
    .SOC_1V8_EN(s18), .REST_EN(ren), .SOC_CORE_PG(scp), .SERDES_CORE_PG(sep),
    .SOC_1V8_PG(s18p), .REST_PG(rp), .CORE_0V75_PG(c75p), .CORE_1V8_EN(c18e),
    .CORE_1V8_PG(c18p), .ALL_UP(all_up), .FAULT(fault));
  for (genvar g = 0; g < 2; g++)
  begin : gs
    dsp_socket #(.SOCKET(g)) u_dsp_socket (.REF_CLK(REF_CLK), .RESET(RESET), .LINK(link),
      .BOOT_ACTIVE(ba[g]), .SEQ_DONE(sd[g]), .CORE_0V75_EN(c75e[g]), .MAX_FREQ_MODE(mf),
      .AVS_ENABLE(adaptive_voltage_scaling), .MONITOR_ENABLE(mon), .PM_REQ(rq), .PM_ADDR(ad), .PM_CMD(8'h5a),
      .PM_DATA({1'h0, ad}), .PM_BUSY(busy[g]), .PM_DONE(done[g]), .PM_NACK(nack[g]),
      .SCL_O(), .SCL_OE(scloe[g]), .SDA_I(~sdaoe[g]), .SDA_O(), .SDA_OE(sdaoe[g]));
  end
  // Clock
  initial
  begin
    REF_CLK = 0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Regulators follow their enables one cycle later
  always @(posedge REF_CLK)
  begin
    scp <= sce & ~kill;
    sep <= see;
    s18p <= s18;
    rp <= ren;
    c75p <= c75e;
    c18p <= c18e;
  end
  // Count clock falls of socket 0 on the regulator port
  always @(posedge REF_CLK)
  begin
    scl_prev <= scloe[0];
    if (RESET)
      scl_falls <= 0;
    else if (scloe[0] && !scl_prev)
      scl_falls <= scl_falls + 1;
  end
  // ----------------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tmo(input logic ok);
    chk(ok, 1);
    if (ok !== 1'b1)
      conclude();
  endtask : tmo
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {RESET, start, mf, adaptive_voltage_scaling, mon, rq, ad, kill} = {1'h1, 14'h0000};
    repeat (11) @(negedge REF_CLK);
    chk(link.socket_reset_n, 0);
    chk({all_up, ba, sce}, 0);
    @(posedge REF_CLK) RESET <= 0;
    $display("test reset done");
    @(posedge REF_CLK) start <= 1;
    for (n = 0; n < 3000 && all_up !== 1'b1; n++) @(negedge REF_CLK);
    tmo(all_up);
    chk({link.socket_reset_n, link.soc_domain_power_good_in, ren}, 12'hfff);
    for (n = 0; n < 3000 && sd[1] !== 1'b1; n++) @(negedge REF_CLK);
    tmo(sd[1]);
    chk({sd, c75e, link.boot_handoff_alert_n}, 5'h1f);
    $display("test power-up done");
    // Write frames at each rate and enable
    for (int i = 0; i < 3; i++)
    begin
      @(posedge REF_CLK) {mf, adaptive_voltage_scaling, mon, ad, rq} <= {rows[i][41:32], 1'h1};
      @(posedge REF_CLK) rq <= 0;
      for (n = 0; n < 40000 && done[0] !== 1'b1; n++) @(negedge REF_CLK);
      tmo(done[0]);
      chk(n / rows[i].q, 29 * 4);
      // Both lines released after stop, every ack unanswered
      chk({done, nack, sdaoe, scloe}, 8'hf0);
      // One clock fall per data bit slot plus the start
      chk(scl_falls, 28 * (i + 1));
    end
    @(posedge REF_CLK) {adaptive_voltage_scaling, mon, rq} <= 3'h1;
    repeat (3) @(negedge REF_CLK);
    chk(busy, 0);
    @(posedge REF_CLK) rq <= 0;
    $display("test pmbus done");
    // Lost power good unwinds in reverse
    @(posedge REF_CLK) kill <= 2'h1;
    for (n = 0; n < 20 && link.socket_reset_n !== 2'h0; n++) @(negedge REF_CLK);
    tmo(n < 20);
    chk({fault, link.socket_reset_n}, 3'h4);
    for (n = 0; n < 200 && ren[7:4] !== 4'h0; n++) @(negedge REF_CLK);
    tmo(n < 200);
    chk({sce, s18, ren}, 12'hf0f);
    for (n = 0; n < 200 && sce !== 2'h0; n++) @(negedge REF_CLK);
    tmo(n < 200);
    chk({ren, s18, ba, link.boot_handoff_alert_n}, 1);
    $display("test fault done");
    conclude();
  end
endmodule : dual_socket_power_sequencer_bench
